// ### rtl/uiif_defines.svh
// register offsets, field positions, reset values and codes for the uart
// interrupt identity / queue control block; included by the package and top
`ifndef UIIF_DEFINES_SVH
`define UIIF_DEFINES_SVH

`define UIIF_OFF_IDENTITY     4'h8
`define UIIF_OFF_STATUS       4'h0
`define UIIF_OFF_MASK         4'h4

`define UIIF_BIT_QUEUE_EN     0
`define UIIF_BIT_RX_FLUSH     1
`define UIIF_BIT_TX_FLUSH     2
`define UIIF_BIT_DMA_SEL      3

`define UIIF_ID_NONE          4'h1
`define UIIF_ID_TX_EMPTY      4'h2
`define UIIF_ID_MODEM         4'h0
`define UIIF_ID_RX_DATA       4'h4
`define UIIF_ID_LINE_STATUS   4'h6
`define UIIF_ID_BUSY          4'h7
`define UIIF_ID_CHAR_TIMEOUT  4'hc

`define UIIF_RST_IDENTITY     4'h1
`define UIIF_RST_STATUS       2'h0
`define UIIF_RST_MASK         2'h0

`define UIIF_EVT_FLUSH_TX     0
`define UIIF_EVT_FLUSH_RX     1

`endif

// ### rtl/uiif_pkg.sv
// types for the uart interrupt identity / queue control block
// assumes uiif_defines.svh is on the include path
`include "uiif_defines.svh"

package uiif_pkg;
  typedef enum logic [1:0] {
    UIIF_WR_IDLE = 2'b00,
    UIIF_WR_RESP = 2'b01
  } uiif_wr_state_t;

  typedef logic [3:0] uiif_code_t;
endpackage

// ### rtl/uiif_top.sv
// uart interrupt identity and queue control register behind an axi4-lite slave
// assumes interrupt sources arrive as levels from logic on sys_clk
//
// Functional notes
// - read returns four-bit code of top pending source, fixed encodings
// - line status first, then busy, then rx data, then timeout, then tx empty, then modem
// - bit 3 write selects dma request signalling mode zero or one
// - bit 2 write of one flushes tx queue control; self clearing
// - bit 1 write of one flushes rx queue control; self clearing
// - bit 0 write enables or disables both queues together
// - any change of queue enable flushes both queues
// - after reset identity reads 0001, no interrupt pending
`include "uiif_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module uiif_top
  import uiif_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        src_line_status,
  input  wire logic        src_rx_data,
  input  wire logic        src_char_timeout,
  input  wire logic        src_tx_empty,
  input  wire logic        src_modem,
  input  wire logic        src_busy,
  output var  logic        queue_enable,
  output var  logic        dma_signalling_select,
  output var  logic        tx_queue_flush,
  output var  logic        rx_queue_flush,
  output var  logic        irq
);

  uiif_wr_state_t wr_state;
  logic           aw_held;
  logic           w_held;
  logic [3:0]     aw_addr;
  logic [31:0]    w_data;
  logic [3:0]     w_strb;
  logic           wr_fire;
  logic [1:0]     status;
  logic [1:0]     mask;
  logic [1:0]     next_status;
  logic           status_read;
  uiif_code_t     interrupt_identity_code;
  uiif_code_t     next_identity;
  logic [31:0]    next_rdata;
  logic [1:0]     next_rresp;
  logic           wr_ctrl;
  logic           wr_mask;
  logic           low_lane;
  logic           aw_take;
  logic           w_take;
  logic           ar_take;

  // top pending source; busy detect sits above rx data, below line status
  function automatic uiif_code_t uiif_pick(input logic ls, input logic busy,
                                           input logic rxd, input logic cto,
                                           input logic txe, input logic mdm);
    uiif_code_t c;
    c = `UIIF_ID_NONE;
    if (ls) begin
      c = `UIIF_ID_LINE_STATUS;
    end else if (busy) begin
      c = `UIIF_ID_BUSY;
    end else if (rxd) begin
      c = `UIIF_ID_RX_DATA;
    end else if (cto) begin
      c = `UIIF_ID_CHAR_TIMEOUT;
    end else if (txe) begin
      c = `UIIF_ID_TX_EMPTY;
    end else if (mdm) begin
      c = `UIIF_ID_MODEM;
    end
    return c;
  endfunction

  function automatic logic uiif_hit(input logic [3:0] a, input logic [3:0] off);
    return a[3:2] == off[3:2];
  endfunction

  // any of the three words this block answers for
  function automatic logic uiif_mapped(input logic [3:0] a);
    return uiif_hit(a, `UIIF_OFF_IDENTITY) || uiif_hit(a, `UIIF_OFF_MASK) ||
           uiif_hit(a, `UIIF_OFF_STATUS);
  endfunction

  // a flush bit, or any change of the enable bit, resets that queue's control
  function automatic logic uiif_flush(input logic req, input logic en_new,
                                      input logic en_now);
    return req || (en_new != en_now);
  endfunction

  // write channel: address and data taken in either order, one at a time
  assign aw_take  = s_axi_awready && s_axi_awvalid;
  assign w_take   = s_axi_wready && s_axi_wvalid;
  assign wr_fire  = aw_held && w_held && (wr_state == UIIF_WR_IDLE);
  assign low_lane = w_strb[0];
  assign wr_ctrl  = wr_fire && low_lane && uiif_hit(aw_addr, `UIIF_OFF_IDENTITY);
  assign wr_mask  = wr_fire && low_lane && uiif_hit(aw_addr, `UIIF_OFF_MASK);

  // the address waits here until its data arrives, in either order
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_addr <= 4'h0;
    end else if (aw_take) begin
      aw_addr <= s_axi_awaddr;
    end
  end

  // ready drops while a word is held, so a second write cannot overrun it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
    end else if (wr_fire || aw_take) begin
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && (wr_state == UIIF_WR_IDLE);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_held <= 1'b0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (w_take) begin
      w_held <= 1'b1;
    end
  end

  // strobe lane 0 gates the effect; the other lanes carry no field
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (w_take) begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b0;
    end else if (wr_fire || w_take) begin
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && (wr_state == UIIF_WR_IDLE);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_state     <= UIIF_WR_IDLE;
      s_axi_bvalid <= 1'b0;
    end else begin
      unique case (wr_state)
        UIIF_WR_IDLE: begin
          if (wr_fire) begin
            wr_state     <= UIIF_WR_RESP;
            s_axi_bvalid <= 1'b1;
          end
        end
        UIIF_WR_RESP: begin
          if (s_axi_bready) begin
            wr_state     <= UIIF_WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state     <= UIIF_WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // bresp is caught with the fire so it stands unchanged while bvalid waits
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bresp <= 2'h0;
    end else if (wr_fire) begin
      // unmapped addresses answer decerr (2'h3)
      s_axi_bresp <= uiif_mapped(aw_addr) ? 2'h0 : 2'h3;
    end
  end

  // enable level; a change of it also flushes both queues below
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      queue_enable <= 1'b0;
    end else if (wr_ctrl) begin
      queue_enable <= w_data[`UIIF_BIT_QUEUE_EN];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_signalling_select <= 1'b0;
    end else if (wr_ctrl) begin
      dma_signalling_select <= w_data[`UIIF_BIT_DMA_SEL];
    end
  end

  // flush strobes last one cycle, so software never has to clear them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_queue_flush <= 1'b0;
    end else begin
      tx_queue_flush <= wr_ctrl && uiif_flush(w_data[`UIIF_BIT_TX_FLUSH],
                                              w_data[`UIIF_BIT_QUEUE_EN],
                                              queue_enable);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_queue_flush <= 1'b0;
    end else begin
      rx_queue_flush <= wr_ctrl && uiif_flush(w_data[`UIIF_BIT_RX_FLUSH],
                                              w_data[`UIIF_BIT_QUEUE_EN],
                                              queue_enable);
    end
  end

  // identity follows sources only; bus writes never reach it
  always_comb begin
    next_identity = uiif_pick(src_line_status, src_busy, src_rx_data,
                              src_char_timeout, src_tx_empty, src_modem);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      interrupt_identity_code <= `UIIF_RST_IDENTITY;
    end else begin
      interrupt_identity_code <= next_identity;
    end
  end

  // sticky flush events; set wins over clear-on-read
  assign ar_take     = s_axi_arready && s_axi_arvalid;
  assign status_read = ar_take && uiif_hit(s_axi_araddr, `UIIF_OFF_STATUS);

  always_comb begin
    next_status = status_read ? 2'h0 : status;
    next_status[`UIIF_EVT_FLUSH_TX] = next_status[`UIIF_EVT_FLUSH_TX] | tx_queue_flush;
    next_status[`UIIF_EVT_FLUSH_RX] = next_status[`UIIF_EVT_FLUSH_RX] | rx_queue_flush;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= `UIIF_RST_STATUS;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask <= `UIIF_RST_MASK;
    end else if (wr_mask) begin
      mask <= w_data[1:0];
    end
  end

  // irq uses the next status and mask, so it never lags the bits it reports
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & (wr_mask ? w_data[1:0] : mask));
    end
  end

  // read channel
  always_comb begin
    next_rdata = 32'h0;
    next_rresp = 2'h0;
    if (uiif_hit(s_axi_araddr, `UIIF_OFF_IDENTITY)) begin
      next_rdata[3:0] = interrupt_identity_code;
    end else if (uiif_hit(s_axi_araddr, `UIIF_OFF_STATUS)) begin
      next_rdata[1:0] = status;
    end else if (uiif_hit(s_axi_araddr, `UIIF_OFF_MASK)) begin
      next_rdata[1:0] = mask;
    end else begin
      next_rresp = 2'h3;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // read data and response are caught at the take and stand until rready
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (ar_take) begin
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule

`default_nettype wire

// ### testbench/uiif_chk.sv
// assertion checker for uiif_top, bound to every instance of it
// assumes the port names and widths of uiif_top
`include "uiif_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module uiif_chk (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_bvalid,
  input wire logic        src_line_status,
  input wire logic        queue_enable,
  input wire logic        dma_signalling_select,
  input wire logic        tx_queue_flush,
  input wire logic        rx_queue_flush
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  tx_self_clear_a: assert property (tx_queue_flush |=> !tx_queue_flush)
    else $error("tx flush held");
  rx_self_clear_a: assert property (rx_queue_flush |=> !rx_queue_flush)
    else $error("rx flush held");
  tx_by_write_a: assert property (tx_queue_flush |-> $rose(s_axi_bvalid))
    else $error("tx flush without write");
  rx_by_write_a: assert property (rx_queue_flush |-> $rose(s_axi_bvalid))
    else $error("rx flush without write");
  enable_flush_a: assert property ($changed(queue_enable)
    |-> tx_queue_flush && rx_queue_flush) else $error("enable change without flush");
  enable_write_a: assert property ($changed(queue_enable) |-> $rose(s_axi_bvalid))
    else $error("enable changed without write");
  dma_write_a: assert property ($changed(dma_signalling_select) |-> $rose(s_axi_bvalid))
    else $error("dma select changed without write");
  line_top_a: assert property ($rose(s_axi_rvalid)
    && $past(s_axi_araddr) == `UIIF_OFF_IDENTITY && $past(src_line_status)
    && $past(src_line_status, 2) && $past(src_line_status, 3)
    |-> s_axi_rdata[3:0] == `UIIF_ID_LINE_STATUS) else $error("line status not on top");
endmodule
bind uiif_top uiif_chk chk (.*);
`default_nettype wire

// ### testbench/uiif_src_model.sv
// interrupt source model standing in for the uart core
// assumes the bench changes want just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module uiif_src_model (
  input  wire logic       sys_clk,
  input  wire logic [5:0] want,
  output var  logic [5:0] src
);
  // levels move only on the clock, as the core's registered flags do
  always_ff @(posedge sys_clk) begin
    src <= want;
  end
endmodule
`default_nettype wire

// ### testbench/uart_interrupt_id_fifo_control_tb.sv
// self-checking bench for uiif_top over axi4-lite with a source model
// assumes the rtl files and uiif_defines.svh are compiled first
`include "uiif_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module uart_interrupt_id_fifo_control_tb;
  logic        sys_clk = 1'b0, rst_n = 1'b0;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        queue_enable, dma_signalling_select, tx_queue_flush, rx_queue_flush, irq;
  logic [5:0]  want = '0, src;
  int          miscompares = 0, compares = 0, ntx = 0, nrx = 0, i;
  logic [5:0]  pv [7] = '{6'h3f, 6'h1f, 6'h0f, 6'h07, 6'h03, 6'h01, 6'h00};
  logic [3:0]  pc [7] = '{`UIIF_ID_LINE_STATUS, `UIIF_ID_BUSY, `UIIF_ID_RX_DATA,
    `UIIF_ID_CHAR_TIMEOUT, `UIIF_ID_TX_EMPTY, `UIIF_ID_MODEM, `UIIF_ID_NONE};
  logic [3:0]  wd [5] = '{4'h9, 4'h9, 4'hd, 4'hb, 4'h0};
  logic [7:0]  wf [5] = '{8'h11, 8'h11, 8'h21, 8'h22, 8'h33};
  wire logic   src_line_status = src[5];
  wire logic   src_busy = src[4];
  wire logic   src_rx_data = src[3];
  wire logic   src_char_timeout = src[2];
  wire logic   src_tx_empty = src[1];
  wire logic   src_modem = src[0];
  uiif_src_model model (.sys_clk(sys_clk), .want(want), .src(src));
  uiif_top DUT (.*);
  always #12.5 sys_clk = ~sys_clk;
  // flush pulses last one cycle, so each is counted at the edge that sees it
  always @(posedge sys_clk) begin
    if (tx_queue_flush === 1'b1) ntx <= ntx + 1;
    if (rx_queue_flush === 1'b1) nrx <= nrx + 1;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task final_report;
    if (miscompares == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", 8'(er), 8'(s_axi_bresp));
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [3:0] a, input logic [3:0] e, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", 8'(e), s_axi_rdata[7:0]);
    chk("rresp", 8'(er), 8'(s_axi_rresp));
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`UIIF_OFF_IDENTITY, `UIIF_ID_NONE, 2'h0);
    rd(`UIIF_OFF_MASK, 4'h0, 2'h0);
    for (i = 0; i < 7; i++) begin
      want <= pv[i];
      repeat (4) @(posedge sys_clk);
      rd(`UIIF_OFF_IDENTITY, pc[i], 2'h0);
    end
    want <= 6'h02;
    wr(`UIIF_OFF_MASK, 32'h3, 2'h0);
    for (i = 0; i < 5; i++) begin
      wr(`UIIF_OFF_IDENTITY, 32'(wd[i]), 2'h0);
      chk("flush_count", wf[i], 8'(ntx * 16 + nrx));
      chk("queue_enable", 8'(wd[i][0]), 8'(queue_enable));
      chk("dma_select", 8'(wd[i][3]), 8'(dma_signalling_select));
    end
    s_axi_wstrb <= 4'h0;
    wr(`UIIF_OFF_IDENTITY, 32'hf, 2'h0);
    s_axi_wstrb <= 4'hf;
    chk("strobe_off", 8'h33, 8'(ntx * 16 + nrx));
    chk("queue_enable", 8'h0, 8'(queue_enable));
    chk("dma_select", 8'h0, 8'(dma_signalling_select));
    rd(`UIIF_OFF_IDENTITY, `UIIF_ID_TX_EMPTY, 2'h0);
    chk("irq", 8'h1, 8'(irq));
    rd(`UIIF_OFF_STATUS, 4'h3, 2'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq", 8'h0, 8'(irq));
    wr(`UIIF_OFF_MASK, 32'h0, 2'h0);
    wr(`UIIF_OFF_IDENTITY, 32'h6, 2'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq", 8'h0, 8'(irq));
    rd(`UIIF_OFF_STATUS, 4'h3, 2'h0);
    rd(4'hc, 4'h0, 2'h3);
    wr(4'hc, 32'h1, 2'h3);
    final_report();
  end
endmodule
`default_nettype wire
